// file: sadc_afe_model.sv
// Purpose: analog front end seen by the converter control block
// Assumes: ideal comparator against the trial word, level set by the bench
// Notes: output is scrambled while sampling, since a real comparator is unsettled there
`timescale 1ns/1ps
module sadc_afe_model (
    // Clock
    input wire logic clk_sys,
    // From the converter
    input wire logic [11:0] dac_code,
    input wire logic sample_hold,
    // Analog level under test
    input wire logic [11:0] level,
    // To the converter
    output logic cmp_in
);
    logic tog_ff = 1'b0;

    // Changes every cycle so a sampled-phase decision is never trusted
    always_ff @(posedge clk_sys)
    begin
        tog_ff <= ~tog_ff;
    end

    // Ideal decision outside the sampling phase
    assign cmp_in = sample_hold ? tog_ff : (level >= dac_code);
endmodule

// file: sadc_ctrl.sv
// Purpose: control of a 12-bit successive approximation converter
// Assumes: one clock, synchronous reset, register bus synchronous to clk_sys
// Notes: result and status reads return one cycle after the read strobe
// Operation
// - Conversion clock is system clock divided by 32, 16, 8 or 4 per select code.
// - Writing 1 to start bit begins conversion; hardware clears it at completion.
// - Software writing 0 to start bit clears it and stops conversion.
// - Completion sets done flag; interrupt request raised when converter interrupt enabled.
// - Done flag clears on flag-register write with bit 0, or start write.
// - Conversion lasts 50 conversion clocks: sample, then two per result bit.
// - Result registers load in the same moment the done flag sets.
// - Four-bit channel code routes inputs, bandgap, or quarter supply to multiplexer.
// - Reference select picks supply for 00, scaled bandgap for 01; rest reserved.
// - Selecting bandgap channel enables the bandgap generator automatically.
// - Force bit keeps bandgap on, also in idle, but off in stop or halt.
`timescale 1ns/1ps
module sadc_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Interrupt and power mode
    input wire logic conv_int_enable,
    input wire logic idle_mode,
    input wire logic stop_halt_mode,
    output logic conv_irq,
    // Analog front end
    input wire logic cmp_in,
    output logic [3:0] input_channel_code,
    output logic channel_valid,
    output logic [1:0] reference_source_sel,
    output logic reference_valid,
    output logic bandgap_reference_en,
    output logic sample_hold,
    output logic [11:0] dac_code,
    output logic conv_busy
);

    // Is the code the bandgap channel
    function automatic logic is_bandgap(input logic [3:0] code);
        is_bandgap = (code == sadc_pkg::CHAN_BANDGAP);
    endfunction

    // Divider ratio from select code
    function automatic logic [5:0] div_ratio(input logic [1:0] sel);
        unique case (sel)
            sadc_pkg::DIV_SEL_32: div_ratio = sadc_pkg::DIV_RATIO_32;
            sadc_pkg::DIV_SEL_16: div_ratio = sadc_pkg::DIV_RATIO_16;
            sadc_pkg::DIV_SEL_8: div_ratio = sadc_pkg::DIV_RATIO_8;
            sadc_pkg::DIV_SEL_4: div_ratio = sadc_pkg::DIV_RATIO_4;
        endcase
    endfunction

    logic [1:0] conv_clock_divider_sel_ff;
    logic [3:0] chan_ff;
    logic [1:0] vref_ff;
    logic bandgap_force_on_ff;
    logic conv_start_bit_ff;
    logic conv_done_flag_ff;
    logic [11:0] result_ff;
    logic [11:0] sar_ff;
    logic [5:0] div_cnt_ff;
    logic [5:0] cyc_ff;
    logic [7:0] rdata_ff;
    logic conv_tick;
    logic done_pulse;
    logic wr_option;
    logic wr_flags;
    logic wr_aux;
    logic wr_channel_ref_register;
    logic start_wr;
    logic stop_wr;
    logic [5:0] bit_offs;
    logic [3:0] bit_idx;

    // Write decodes
    assign wr_option = sfr_wr && (sfr_addr == sadc_pkg::ADDR_OPTION_CLOCK_SELECT);
    assign wr_flags = sfr_wr && (sfr_addr == sadc_pkg::ADDR_INTERRUPT_FLAGS);
    assign wr_aux = sfr_wr && (sfr_addr == sadc_pkg::ADDR_AUXILIARY_CONTROL_ONE);
    assign wr_channel_ref_register = sfr_wr && (sfr_addr == sadc_pkg::ADDR_CHANNEL_REF_REGISTER);
    assign start_wr = wr_aux && sfr_wdata[sadc_pkg::START_BIT];
    assign stop_wr = wr_aux && !sfr_wdata[sadc_pkg::START_BIT];

    // Divider tick only while converting, so each conversion starts phase aligned
    // Compare with at-least so a smaller ratio chosen mid-period takes effect at once, not after a wrap
    assign conv_tick = conv_start_bit_ff && (div_cnt_ff >= div_ratio(conv_clock_divider_sel_ff) - 6'h01);
    assign done_pulse = conv_tick && (cyc_ff == sadc_pkg::CONV_TOTAL_CYCLES - 6'h01);
    assign bit_offs = cyc_ff - sadc_pkg::CONV_SAMPLE_CYCLES;
    assign bit_idx = 4'hb - bit_offs[4:1];

    // Configuration fields
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            conv_clock_divider_sel_ff <= sadc_pkg::DIV_SEL_RST;
            chan_ff <= sadc_pkg::CHAN_RST;
            vref_ff <= sadc_pkg::VREF_RST;
            bandgap_force_on_ff <= sadc_pkg::BG_FORCE_RST;
        end
        else
        begin
            if (wr_option)
                conv_clock_divider_sel_ff <= sfr_wdata[sadc_pkg::DIV_SEL_LSB +: 2];
            if (wr_channel_ref_register)
            begin
                chan_ff <= sfr_wdata[sadc_pkg::CHAN_LSB +: 4];
                vref_ff <= sfr_wdata[sadc_pkg::VREF_LSB +: 2];
                bandgap_force_on_ff <= sfr_wdata[sadc_pkg::BG_FORCE_BIT];
            end
        end
    end

    // Start bit; a write in the completion cycle takes precedence
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            conv_start_bit_ff <= 1'b0;
        else if (start_wr)
            conv_start_bit_ff <= 1'b1;
        else if (stop_wr)
            conv_start_bit_ff <= 1'b0;
        else if (done_pulse)
            conv_start_bit_ff <= 1'b0;
    end

    // Done flag; completion wins over any clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            conv_done_flag_ff <= 1'b0;
        else if (done_pulse)
            conv_done_flag_ff <= 1'b1;
        else if (start_wr || (wr_flags && !sfr_wdata[sadc_pkg::DONE_FLAG_BIT]))
            conv_done_flag_ff <= 1'b0;
    end

    // Divider and conversion cycle counters, restarted by every start write
    always_ff @(posedge clk_sys)
    begin
        if (srst || start_wr || !conv_start_bit_ff)
        begin
            div_cnt_ff <= 6'h00;
            cyc_ff <= 6'h00;
        end
        else if (conv_tick)
        begin
            div_cnt_ff <= 6'h00;
            cyc_ff <= done_pulse ? 6'h00 : cyc_ff + 6'h01;
        end
        else
            div_cnt_ff <= div_cnt_ff + 6'h01;
    end

    // Approximation: first clock of a pair tries the bit, second keeps or drops it
    always_ff @(posedge clk_sys)
    begin
        if (srst || start_wr)
            sar_ff <= 12'h000;
        else if (conv_tick && (cyc_ff >= sadc_pkg::CONV_SAMPLE_CYCLES))
        begin
            if (!bit_offs[0])
                sar_ff[bit_idx] <= 1'b1;
            else
                sar_ff[bit_idx] <= cmp_in;
        end
    end

    // Result captured together with the flag; bus writes never touch it
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            result_ff <= 12'h000;
        else if (done_pulse)
            result_ff <= {sar_ff[11:1], cmp_in};
    end

    // Registered read data; other owners' bits read zero here
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_ff <= 8'h00;
        else if (sfr_rd)
        begin
            unique case (sfr_addr)
                sadc_pkg::ADDR_OPTION_CLOCK_SELECT:
                    rdata_ff <= {4'h0, conv_clock_divider_sel_ff, 2'h0};
                sadc_pkg::ADDR_INTERRUPT_FLAGS:
                    rdata_ff <= {3'h0, conv_done_flag_ff, 4'h0};
                sadc_pkg::ADDR_CONV_RESULT_LOW:
                    rdata_ff <= {result_ff[3:0], 4'h0};
                sadc_pkg::ADDR_CONV_RESULT_HIGH:
                    rdata_ff <= result_ff[11:4];
                sadc_pkg::ADDR_CHANNEL_REF_REGISTER:
                    rdata_ff <= {chan_ff, vref_ff, bandgap_force_on_ff, 1'b0};
                sadc_pkg::ADDR_AUXILIARY_CONTROL_ONE:
                    rdata_ff <= {3'h0, conv_start_bit_ff, 4'h0};
                default:
                    rdata_ff <= 8'h00;
            endcase
        end
    end

    // Analog side; reserved codes are flagged, not remapped
    assign input_channel_code = chan_ff;
    assign channel_valid = (chan_ff != sadc_pkg::CHAN_RESERVED);
    assign reference_source_sel = vref_ff;
    assign reference_valid = (vref_ff == sadc_pkg::VREF_SUPPLY) || (vref_ff == sadc_pkg::VREF_BANDGAP_SCALED);
    // Stop and halt override even the force bit; idle does not
    assign bandgap_reference_en = !stop_halt_mode && (bandgap_force_on_ff || is_bandgap(chan_ff));
    assign sample_hold = conv_start_bit_ff && (cyc_ff < sadc_pkg::CONV_SAMPLE_CYCLES);
    assign dac_code = sar_ff;
    assign conv_busy = conv_start_bit_ff;
    assign conv_irq = conv_done_flag_ff && conv_int_enable;
    assign sfr_rdata = rdata_ff;

    // Helper: system cycles since the last conversion clock or start write, conversion clocks since the start write
    logic [5:0] gap_cnt;
    logic [6:0] tick_cnt;
    always_ff @(posedge clk_sys)
    begin
        if (srst || start_wr || conv_tick)
            gap_cnt <= 6'h00;
        else
            gap_cnt <= gap_cnt + 6'h01;
        if (srst || start_wr)
            tick_cnt <= 7'h00;
        else if (conv_tick)
            tick_cnt <= tick_cnt + 7'h01;
    end

    a_div_period: assert property (@(posedge clk_sys) disable iff (srst)
        conv_tick && !$past(wr_option) && $past(conv_start_bit_ff) |-> gap_cnt == div_ratio(conv_clock_divider_sel_ff) - 6'h01)
        else $error("conversion clock period wrong");
    a_start_autoclr: assert property (@(posedge clk_sys) disable iff (srst)
        done_pulse && !sfr_wr |=> !conv_start_bit_ff && !conv_busy)
        else $error("start bit not cleared at completion");
    a_start_swclr: assert property (@(posedge clk_sys) disable iff (srst)
        stop_wr |=> !conv_start_bit_ff ##1 !conv_done_flag_ff || $past(conv_done_flag_ff))
        else $error("start bit not cleared by software");
    a_flag_on_done: assert property (@(posedge clk_sys) disable iff (srst)
        done_pulse |=> conv_done_flag_ff && (conv_irq == conv_int_enable))
        else $error("done flag or request missing");
    a_flag_clear: assert property (@(posedge clk_sys) disable iff (srst)
        !done_pulse && (start_wr || (wr_flags && !sfr_wdata[sadc_pkg::DONE_FLAG_BIT])) |=> !conv_done_flag_ff)
        else $error("done flag not cleared");
    a_conv_length: assert property (@(posedge clk_sys) disable iff (srst)
        done_pulse |-> tick_cnt == 7'(sadc_pkg::CONV_TOTAL_CYCLES - 6'h01))
        else $error("conversion not fifty clocks");
    a_result_load: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(conv_done_flag_ff) |-> result_ff != $past(result_ff) || $past(done_pulse))
        else $error("flag set without result load");
    a_low_nibble: assert property (@(posedge clk_sys) disable iff (srst)
        sfr_rd && sfr_addr == sadc_pkg::ADDR_CONV_RESULT_LOW |=> sfr_rdata == {result_ff[3:0], 4'h0})
        else $error("low result read wrong");
    a_bandgap_auto: assert property (@(posedge clk_sys) disable iff (srst)
        is_bandgap(input_channel_code) && !stop_halt_mode |-> bandgap_reference_en)
        else $error("bandgap not enabled for its channel");
    a_bandgap_stop: assert property (@(posedge clk_sys) disable iff (srst)
        stop_halt_mode |-> !bandgap_reference_en)
        else $error("bandgap on in stop or halt");
    a_bandgap_idle: assert property (@(posedge clk_sys) disable iff (srst)
        idle_mode && bandgap_force_on_ff && !stop_halt_mode |-> bandgap_reference_en)
        else $error("forced bandgap off in idle");

    // Register view, phase and level checks
    a_high_byte: assert property (@(posedge clk_sys) disable iff (srst)
        sfr_rd && sfr_addr == sadc_pkg::ADDR_CONV_RESULT_HIGH && !done_pulse |=> sfr_rdata == result_ff[11:4])
        else $error("high result read wrong");
    a_result_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !done_pulse |=> $stable(result_ff))
        else $error("result changed outside completion");
    a_flag_hold: assert property (@(posedge clk_sys) disable iff (srst)
        conv_done_flag_ff && !start_wr && !(wr_flags && !sfr_wdata[sadc_pkg::DONE_FLAG_BIT]) |=> conv_done_flag_ff)
        else $error("done flag lost without a clear");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (srst)
        conv_irq |-> conv_done_flag_ff && conv_int_enable)
        else $error("request without flag and enable");
    a_sar_clear: assert property (@(posedge clk_sys) disable iff (srst)
        start_wr |=> dac_code == 12'h000 && sample_hold)
        else $error("start did not open a fresh sample");
    a_hold_no_trial: assert property (@(posedge clk_sys) disable iff (srst)
        sample_hold |-> dac_code == 12'h000)
        else $error("trial bits set while sampling");
    a_sample_len: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(sample_hold) && conv_busy |-> tick_cnt == 7'(sadc_pkg::CONV_SAMPLE_CYCLES))
        else $error("sample phase length wrong");
    a_chan_reserved: assert property (@(posedge clk_sys) disable iff (srst)
        channel_valid == (input_channel_code != sadc_pkg::CHAN_RESERVED))
        else $error("reserved channel not flagged");
    a_ref_valid: assert property (@(posedge clk_sys) disable iff (srst)
        reference_valid == !reference_source_sel[1])
        else $error("reserved reference not flagged");
    a_bg_auto_off: assert property (@(posedge clk_sys) disable iff (srst)
        !bandgap_force_on_ff && !is_bandgap(input_channel_code) |-> !bandgap_reference_en)
        else $error("bandgap on without force or channel");

endmodule

// file: sadc_pkg.sv
// Purpose: shared constants of the converter control block
// Assumes: 8-bit special function register bus, byte addresses
// Notes: only the converter fields of shared registers live here
package sadc_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_OPTION_CLOCK_SELECT = 8'h94;
    localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h95;
    localparam logic [7:0] ADDR_CONV_RESULT_LOW = 8'haa;
    localparam logic [7:0] ADDR_CONV_RESULT_HIGH = 8'hab;
    localparam logic [7:0] ADDR_CHANNEL_REF_REGISTER = 8'hae;
    localparam logic [7:0] ADDR_AUXILIARY_CONTROL_ONE = 8'hf8;

    // Field positions
    localparam int DIV_SEL_LSB = 2;
    localparam int DONE_FLAG_BIT = 4;
    localparam int START_BIT = 4;
    localparam int CHAN_LSB = 4;
    localparam int VREF_LSB = 2;
    localparam int BG_FORCE_BIT = 1;

    // Reset values
    localparam logic [1:0] DIV_SEL_RST = 2'h0;
    localparam logic [3:0] CHAN_RST = 4'hf;
    localparam logic [1:0] VREF_RST = 2'h0;
    localparam logic BG_FORCE_RST = 1'b0;

    // Divider codes and ratios
    localparam logic [1:0] DIV_SEL_32 = 2'h0;
    localparam logic [1:0] DIV_SEL_16 = 2'h1;
    localparam logic [1:0] DIV_SEL_8 = 2'h2;
    localparam logic [1:0] DIV_SEL_4 = 2'h3;
    localparam logic [5:0] DIV_RATIO_32 = 6'h20;
    localparam logic [5:0] DIV_RATIO_16 = 6'h10;
    localparam logic [5:0] DIV_RATIO_8 = 6'h08;
    localparam logic [5:0] DIV_RATIO_4 = 6'h04;

    // Conversion timing in conversion clocks
    localparam logic [5:0] RESULT_BITS = 6'h0c;
    localparam logic [5:0] CONV_TOTAL_CYCLES = 6'h32;
    localparam logic [5:0] CONV_SAMPLE_CYCLES = CONV_TOTAL_CYCLES - 6'(2 * RESULT_BITS);

    // Channel and reference codes
    localparam logic [3:0] CHAN_RESERVED = 4'ha;
    localparam logic [3:0] CHAN_BANDGAP = 4'hb;
    localparam logic [3:0] CHAN_QUARTER_SUPPLY = 4'hf;
    localparam logic [1:0] VREF_SUPPLY = 2'h0;
    localparam logic [1:0] VREF_BANDGAP_SCALED = 2'h1;
endpackage

// file: tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: one-cycle register read latency, 200 MHz system clock
// Notes: the comparator partner makes each conversion return the applied level
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, srst, sfr_wr, sfr_rd, cmp_in, conv_irq, conv_busy, sample_hold;
    logic conv_int_enable, idle_mode, stop_halt_mode, channel_valid, reference_valid, bandgap_reference_en;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [3:0] input_channel_code;
    logic [1:0] reference_source_sel;
    logic [11:0] dac_code, level;
    int failures = 0;
    int cmp_count = 0;

    sadc_ctrl i_sadc_ctrl (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_int_enable(conv_int_enable),
        .idle_mode(idle_mode), .stop_halt_mode(stop_halt_mode), .conv_irq(conv_irq), .cmp_in(cmp_in),
        .input_channel_code(input_channel_code), .channel_valid(channel_valid),
        .reference_source_sel(reference_source_sel), .reference_valid(reference_valid),
        .bandgap_reference_en(bandgap_reference_en), .sample_hold(sample_hold), .dac_code(dac_code),
        .conv_busy(conv_busy));
    sadc_afe_model i_sadc_afe_model (.clk_sys(clk_sys), .dac_code(dac_code), .sample_hold(sample_hold),
        .level(level), .cmp_in(cmp_in));

    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Strobe held for exactly the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        chk_byte($sformatf("reg_%h", a), e, sfr_rdata);
    endtask

    // One conversion; the edge right at completion is left unchecked on purpose
    task automatic convert(input logic [1:0] dsel, input logic [11:0] v);
        int div;
        div = 32 >> dsel;
        level <= v;
        wr(8'h94, {4'h0, dsel, 2'h0});
        wr(8'hf8, 8'h10);
        #1;
        chk_bit("busy", 1'b1, conv_busy);
        chk_bit("sample", 1'b1, sample_hold);
        repeat (50 * div - 1) @(posedge clk_sys);
        #1;
        chk_bit("busy_late", 1'b1, conv_busy);
        chk_bit("irq_early", 1'b0, conv_irq);
        repeat (2) @(posedge clk_sys);
        #1;
        chk_bit("busy_end", 1'b0, conv_busy);
        chk_bit("irq", 1'b1, conv_irq);
        chk_rd(8'hab, v[11:4]);
        chk_rd(8'haa, {v[3:0], 4'h0});
        chk_rd(8'h95, 8'h10);
        chk_rd(8'h94, {4'h0, dsel, 2'h0});
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cut a hang well beyond the expected few thousand cycles
    initial
    begin
        #200000;
        failures++;
        final_report();
    end

    // Main sequence
    initial
    begin
        srst = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        level = 12'h000;
        conv_int_enable = 1'b1;
        idle_mode = 1'b0;
        stop_halt_mode = 1'b0;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        chk_rd(8'h94, 8'h00);
        chk_rd(8'hae, 8'hf0);
        chk_rd(8'hf8, 8'h00);
        chk_rd(8'h95, 8'h00);
        convert(2'h0, 12'ha5c);
        convert(2'h1, 12'hfff);
        convert(2'h2, 12'h000);
        convert(2'h3, 12'h3c1);
        // Masked request, ignored writes, unmapped place
        @(posedge clk_sys);
        conv_int_enable <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk_bit("irq_masked", 1'b0, conv_irq);
        @(posedge clk_sys);
        conv_int_enable <= 1'b1;
        wr(8'hab, 8'h00);
        chk_rd(8'hab, 8'h3c);
        wr(8'h90, 8'hff);
        chk_rd(8'h90, 8'h00);
        // Flag survives a one write, clears on EF
        wr(8'h95, 8'h10);
        chk_rd(8'h95, 8'h10);
        wr(8'h95, 8'hef);
        chk_rd(8'h95, 8'h00);
        #1;
        chk_bit("irq_clr", 1'b0, conv_irq);
        // Start write clears the flag, then an abort yields nothing
        convert(2'h3, 12'h5a5);
        wr(8'hf8, 8'h10);
        chk_rd(8'h95, 8'h00);
        wr(8'hf8, 8'h00);
        #1;
        chk_bit("abort", 1'b0, conv_busy);
        repeat (250) @(posedge clk_sys);
        chk_rd(8'h95, 8'h00);
        chk_rd(8'hab, 8'h5a);
        // Every channel and reference code
        for (int c = 0; c < 16; c++)
        begin
            wr(8'hae, {c[3:0], 4'h0});
            #1;
            chk_byte("chan", {4'h0, c[3:0]}, {4'h0, input_channel_code});
            chk_bit("chan_ok", c != 10, channel_valid);
            chk_bit("bg_auto", c == 11, bandgap_reference_en);
        end
        for (int r = 0; r < 4; r++)
        begin
            wr(8'hae, {6'h00, r[1:0]} << 2);
            #1;
            chk_byte("ref", {6'h00, r[1:0]}, {6'h00, reference_source_sel});
            chk_bit("ref_ok", r < 2, reference_valid);
        end
        wr(8'hae, 8'hb3);
        chk_rd(8'hae, 8'hb2);
        // Forced bandgap through idle, off in stop or halt
        wr(8'hae, 8'h02);
        @(posedge clk_sys);
        idle_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_bit("bg_idle", 1'b1, bandgap_reference_en);
        @(posedge clk_sys);
        stop_halt_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_bit("bg_stop", 1'b0, bandgap_reference_en);
        @(posedge clk_sys);
        stop_halt_mode <= 1'b0;
        wr(8'hae, 8'h00);
        #1;
        chk_bit("bg_auto_off", 1'b0, bandgap_reference_en);
        final_report();
    end
endmodule
